// ===== src/power_mode_pkg.sv
// Register indices, field positions and reset values for the power and mode control block.
package power_mode_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] RF_MODE_IDX = 8'h1a;
  localparam logic [7:0] DIVIDER_MODE_IDX = 8'h1b;
  localparam logic [7:0] ATTEN_LEVEL_IDX = 8'h33;
  localparam logic [7:0] POWER_EN_A_IDX = 8'h6d;
  localparam logic [7:0] POWER_EN_B_IDX = 8'h6e;
  localparam logic [7:0] POWER_EN_C_IDX = 8'h6f;
  localparam logic [7:0] EFFECTIVE_EN_IDX = 8'h70;
  localparam logic [7:0] BIAS_CURRENT_IDX = 8'h75;
  // Field positions in the rf mode register.
  localparam int RF_AMP_LOW_POWER_BIT = 0;
  localparam int BASEBAND_CUTOFF_BIT = 1;
  // Field positions in the divider mode register.
  localparam int DIVIDER_HIGH_POWER_BIT = 0;
  // Field position of the two-bit attenuation step.
  localparam int ATTEN_STEP_LSB = 0;
  // Field positions in the bias current register.
  localparam int GAIN_AMP_CURRENT_LSB = 0;
  localparam int ANTIALIAS_CURRENT_BIT = 2;
  // Power enable group A.
  localparam int REFERENCE_BIT = 0;
  localparam int MOD_CONVERTER_BIT = 1;
  localparam int RATE_CONVERTER_BIT = 2;
  localparam int CLOCK_BUFFER_BIT = 3;
  // Power enable group B.
  localparam int SYNTH_BIT = 0;
  localparam int TRANSMIT_PATH_BIT = 1;
  localparam int DETECTOR_CONVERTER_BIT = 2;
  // Power enable group C.
  localparam int POWER_DETECTOR_BIT = 0;
  localparam int ATTENUATOR_BIT = 1;
  localparam int LOW_NOISE_AMP_BIT = 2;
  localparam int ADC_BIT = 3;
  localparam int RECEIVE_PATH_BIT = 4;
  // Effective enable readback positions.
  localparam int EFF_LOW_NOISE_AMP_BIT = 0;
  localparam int EFF_ATTENUATOR_BIT = 1;
  localparam int EFF_DIVIDER_BIT = 2;
  localparam int EFF_REGULATOR_BIT = 3;
  // Writable bit masks of each writable register; the effective enable readback has none.
  localparam logic [7:0] RF_MODE_MASK = 8'h03;
  localparam logic [7:0] DIVIDER_MODE_MASK = 8'h01;
  localparam logic [7:0] ATTEN_LEVEL_MASK = 8'h03;
  localparam logic [7:0] POWER_EN_A_MASK = 8'h0f;
  localparam logic [7:0] POWER_EN_B_MASK = 8'h07;
  localparam logic [7:0] POWER_EN_C_MASK = 8'h1f;
  localparam logic [7:0] BIAS_CURRENT_MASK = 8'h07;
  // Every writable register clears to zero on reset; the effective enable readback shows the regulator bit from the pin.
  localparam logic [7:0] REG_RESET = 8'h00;
endpackage : power_mode_pkg

// ===== src/rx_tx_power_mode_control.sv
// Power enable and operating mode control for the transceiver analog and clock blocks.
`timescale 1ns/1ns
`default_nettype none
module rx_tx_power_mode_control (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [9:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  input wire logic I_REGULATOR_OFF_PIN,
  output logic O_REGULATOR_POWER_EN,
  output logic O_REFERENCE_POWER_EN,
  output logic O_MOD_CONVERTER_POWER_EN,
  output logic O_SYNTH_POWER_EN,
  output logic O_RATE_CONVERTER_POWER_EN,
  output logic O_CLOCK_BUFFER_POWER_EN,
  output logic O_TRANSMIT_PATH_POWER_EN,
  output logic O_DETECTOR_CONVERTER_POWER_EN,
  output logic O_POWER_DETECTOR_EN,
  output logic O_ATTENUATOR_POWER_EN,
  output logic O_LOW_NOISE_AMP_POWER_EN,
  output logic O_ADC_POWER_EN,
  output logic O_RECEIVE_PATH_POWER_EN,
  output logic O_DIVIDER_POWER_EN,
  output logic O_RF_AMP_LOW_POWER_SEL,
  output logic O_DIVIDER_HIGH_POWER_SEL,
  output logic O_BASEBAND_CUTOFF_SEL,
  output logic [1:0] O_GAIN_AMP_CURRENT_SEL,
  output logic O_ANTIALIAS_CURRENT_SEL,
  output logic [1:0] O_ATTENUATION_STEP
);

  logic [7:0] rf_mode;
  logic [7:0] divider_mode;
  logic [7:0] atten_level;
  logic [7:0] power_en_a;
  logic [7:0] power_en_b;
  logic [7:0] power_en_c;
  logic [7:0] bias_current;
  logic [7:0] next_rf_mode;
  logic [7:0] next_divider_mode;
  logic [7:0] next_atten_level;
  logic [7:0] next_power_en_a;
  logic [7:0] next_power_en_b;
  logic [7:0] next_power_en_c;
  logic [7:0] next_bias_current;
  logic ack;
  logic next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [7:0] index;
  logic req;
  logic wr;
  logic [7:0] effective;
  logic lna_on;
  logic att_on;
  logic divider_on;

  // Masked field update used for every writable register.
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wdata,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (wdata & mask);
  endfunction : merge

  // Address decode shared by the write and read paths.
  function automatic logic hit(input logic [7:0] idx, input logic [7:0] target);
    hit = (idx == target);
  endfunction : hit

  assign index = I_WB_ADR[9:2];
  // A new request is taken only while no answer is pending, so ack is a single cycle.
  assign req = I_WB_CYC && I_WB_STB && !ack;
  assign wr = req && I_WB_WE && I_WB_SEL[0];

  // The attenuator wins when both are enabled, keeping the two parallel paths exclusive.
  assign att_on = power_en_c[power_mode_pkg::ATTENUATOR_BIT];
  assign lna_on = power_en_c[power_mode_pkg::LOW_NOISE_AMP_BIT] && !att_on;
  assign divider_on = power_en_c[power_mode_pkg::RECEIVE_PATH_BIT] ||
                      power_en_b[power_mode_pkg::TRANSMIT_PATH_BIT];

  always_comb begin
    effective = 8'h00;
    effective[power_mode_pkg::EFF_LOW_NOISE_AMP_BIT] = lna_on;
    effective[power_mode_pkg::EFF_ATTENUATOR_BIT] = att_on;
    effective[power_mode_pkg::EFF_DIVIDER_BIT] = divider_on;
    effective[power_mode_pkg::EFF_REGULATOR_BIT] = !I_REGULATOR_OFF_PIN;
  end

  always_comb begin
    next_rf_mode = rf_mode;
    next_divider_mode = divider_mode;
    next_atten_level = atten_level;
    next_power_en_a = power_en_a;
    next_power_en_b = power_en_b;
    next_power_en_c = power_en_c;
    next_bias_current = bias_current;
    if (wr) begin
      if (hit(index, power_mode_pkg::RF_MODE_IDX)) begin
        next_rf_mode = merge(rf_mode, I_WB_DAT[7:0], power_mode_pkg::RF_MODE_MASK);
      end else if (hit(index, power_mode_pkg::DIVIDER_MODE_IDX)) begin
        next_divider_mode = merge(divider_mode, I_WB_DAT[7:0],
                                  power_mode_pkg::DIVIDER_MODE_MASK);
      end else if (hit(index, power_mode_pkg::ATTEN_LEVEL_IDX)) begin
        next_atten_level = merge(atten_level, I_WB_DAT[7:0], power_mode_pkg::ATTEN_LEVEL_MASK);
      end else if (hit(index, power_mode_pkg::POWER_EN_A_IDX)) begin
        next_power_en_a = merge(power_en_a, I_WB_DAT[7:0],
                                power_mode_pkg::POWER_EN_A_MASK);
      end else if (hit(index, power_mode_pkg::POWER_EN_B_IDX)) begin
        next_power_en_b = merge(power_en_b, I_WB_DAT[7:0],
                                power_mode_pkg::POWER_EN_B_MASK);
      end else if (hit(index, power_mode_pkg::POWER_EN_C_IDX)) begin
        next_power_en_c = merge(power_en_c, I_WB_DAT[7:0],
                                power_mode_pkg::POWER_EN_C_MASK);
      end else if (hit(index, power_mode_pkg::BIAS_CURRENT_IDX)) begin
        next_bias_current = merge(bias_current, I_WB_DAT[7:0],
                                  power_mode_pkg::BIAS_CURRENT_MASK);
      end
    end
  end

  always_comb begin
    next_ack = req;
    next_rdata = rdata;
    if (req && !I_WB_WE) begin
      next_rdata = 32'h0000_0000;
      if (hit(index, power_mode_pkg::RF_MODE_IDX)) begin
        next_rdata[7:0] = rf_mode;
      end else if (hit(index, power_mode_pkg::DIVIDER_MODE_IDX)) begin
        next_rdata[7:0] = divider_mode;
      end else if (hit(index, power_mode_pkg::ATTEN_LEVEL_IDX)) begin
        next_rdata[7:0] = atten_level;
      end else if (hit(index, power_mode_pkg::POWER_EN_A_IDX)) begin
        next_rdata[7:0] = power_en_a;
      end else if (hit(index, power_mode_pkg::POWER_EN_B_IDX)) begin
        next_rdata[7:0] = power_en_b;
      end else if (hit(index, power_mode_pkg::POWER_EN_C_IDX)) begin
        next_rdata[7:0] = power_en_c;
      end else if (hit(index, power_mode_pkg::EFFECTIVE_EN_IDX)) begin
        next_rdata[7:0] = effective;
      end else if (hit(index, power_mode_pkg::BIAS_CURRENT_IDX)) begin
        next_rdata[7:0] = bias_current;
      end
    end
  end

  // The reset is synchronous, so while it is low every write is simply overridden.
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      rf_mode <= power_mode_pkg::REG_RESET;
      divider_mode <= power_mode_pkg::REG_RESET;
      atten_level <= power_mode_pkg::REG_RESET;
      power_en_a <= power_mode_pkg::REG_RESET;
      power_en_b <= power_mode_pkg::REG_RESET;
      power_en_c <= power_mode_pkg::REG_RESET;
      bias_current <= power_mode_pkg::REG_RESET;
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      rf_mode <= next_rf_mode;
      divider_mode <= next_divider_mode;
      atten_level <= next_atten_level;
      power_en_a <= next_power_en_a;
      power_en_b <= next_power_en_b;
      power_en_c <= next_power_en_c;
      bias_current <= next_bias_current;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign O_WB_ACK = ack;
  assign O_WB_DAT = rdata;
  // The sequencing of the reference against blocks seven to thirteen is left to software.
  assign O_REGULATOR_POWER_EN = !I_REGULATOR_OFF_PIN;
  assign O_REFERENCE_POWER_EN = power_en_a[power_mode_pkg::REFERENCE_BIT];
  assign O_MOD_CONVERTER_POWER_EN = power_en_a[power_mode_pkg::MOD_CONVERTER_BIT];
  assign O_RATE_CONVERTER_POWER_EN = power_en_a[power_mode_pkg::RATE_CONVERTER_BIT];
  assign O_CLOCK_BUFFER_POWER_EN = power_en_a[power_mode_pkg::CLOCK_BUFFER_BIT];
  assign O_SYNTH_POWER_EN = power_en_b[power_mode_pkg::SYNTH_BIT];
  assign O_TRANSMIT_PATH_POWER_EN = power_en_b[power_mode_pkg::TRANSMIT_PATH_BIT];
  assign O_DETECTOR_CONVERTER_POWER_EN =
    power_en_b[power_mode_pkg::DETECTOR_CONVERTER_BIT];
  assign O_POWER_DETECTOR_EN = power_en_c[power_mode_pkg::POWER_DETECTOR_BIT];
  assign O_ATTENUATOR_POWER_EN = att_on;
  assign O_LOW_NOISE_AMP_POWER_EN = lna_on;
  assign O_ADC_POWER_EN = power_en_c[power_mode_pkg::ADC_BIT];
  assign O_RECEIVE_PATH_POWER_EN = power_en_c[power_mode_pkg::RECEIVE_PATH_BIT];
  assign O_DIVIDER_POWER_EN = divider_on;
  assign O_RF_AMP_LOW_POWER_SEL = rf_mode[power_mode_pkg::RF_AMP_LOW_POWER_BIT];
  assign O_BASEBAND_CUTOFF_SEL = rf_mode[power_mode_pkg::BASEBAND_CUTOFF_BIT];
  assign O_DIVIDER_HIGH_POWER_SEL = divider_mode[power_mode_pkg::DIVIDER_HIGH_POWER_BIT];
  assign O_GAIN_AMP_CURRENT_SEL =
    bias_current[power_mode_pkg::GAIN_AMP_CURRENT_LSB +: 2];
  assign O_ANTIALIAS_CURRENT_SEL = bias_current[power_mode_pkg::ANTIALIAS_CURRENT_BIT];
  // Code 00 is the lightest step and 11 the heaviest, each 6dB apart.
  assign O_ATTENUATION_STEP = atten_level[power_mode_pkg::ATTEN_STEP_LSB +: 2];

  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);

  a_lna_att_exclusive: assert property (
    !(O_LOW_NOISE_AMP_POWER_EN && O_ATTENUATOR_POWER_EN))
    else $error("Amplifier and attenuator powered together.");

  a_lna_decode: assert property (
    O_LOW_NOISE_AMP_POWER_EN == (power_en_c[power_mode_pkg::LOW_NOISE_AMP_BIT] &&
                                 !power_en_c[power_mode_pkg::ATTENUATOR_BIT]))
    else $error("Amplifier power decode wrong.");

  a_divider_or: assert property (
    O_DIVIDER_POWER_EN == (O_RECEIVE_PATH_POWER_EN || O_TRANSMIT_PATH_POWER_EN))
    else $error("Divider enable is not the or of the path enables.");

  a_regulator_pin: assert property (
    O_REGULATOR_POWER_EN != I_REGULATOR_OFF_PIN)
    else $error("Regulator enable does not follow the pin.");

  a_write_enables_c: assert property (
    wr && hit(index, power_mode_pkg::POWER_EN_C_IDX) |=>
      O_RECEIVE_PATH_POWER_EN == $past(I_WB_DAT[power_mode_pkg::RECEIVE_PATH_BIT]))
    else $error("Receive path enable did not take the written value.");

  a_write_reference: assert property (
    wr && hit(index, power_mode_pkg::POWER_EN_A_IDX) |=>
      O_REFERENCE_POWER_EN == $past(I_WB_DAT[power_mode_pkg::REFERENCE_BIT]))
    else $error("Reference enable did not take the written value.");

  a_write_atten_step: assert property (
    wr && hit(index, power_mode_pkg::ATTEN_LEVEL_IDX) |=>
      O_ATTENUATION_STEP == $past(I_WB_DAT[1:0]))
    else $error("Attenuation step did not take the written value.");

  a_rf_amp_mode: assert property (
    wr && hit(index, power_mode_pkg::RF_MODE_IDX) |=>
      O_RF_AMP_LOW_POWER_SEL == $past(I_WB_DAT[power_mode_pkg::RF_AMP_LOW_POWER_BIT]))
    else $error("Amplifier power mode did not take the written value.");

  a_bias_hold: assert property (
    !(wr && hit(index, power_mode_pkg::BIAS_CURRENT_IDX)) |=> $stable(O_GAIN_AMP_CURRENT_SEL))
    else $error("Gain amplifier current changed without a write.");

  a_reset_clears: assert property (@(posedge I_CLK_SYS) disable iff (1'b0)
    !I_RST_N |=> !O_REFERENCE_POWER_EN && !O_RECEIVE_PATH_POWER_EN && !O_SYNTH_POWER_EN &&
                 !O_WB_ACK)
    else $error("Reset did not clear the enables.");

  a_ack_single: assert property (
    I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK ##1 !O_WB_ACK)
    else $error("Bus answer is not a single cycle.");

  a_divider_mode_write: assert property (
    wr && hit(index, power_mode_pkg::DIVIDER_MODE_IDX) |=>
      O_DIVIDER_HIGH_POWER_SEL == $past(I_WB_DAT[power_mode_pkg::DIVIDER_HIGH_POWER_BIT]))
    else $error("Divider power mode did not take the written value.");

  a_cutoff_write: assert property (
    wr && hit(index, power_mode_pkg::RF_MODE_IDX) |=>
      O_BASEBAND_CUTOFF_SEL == $past(I_WB_DAT[power_mode_pkg::BASEBAND_CUTOFF_BIT]))
    else $error("Cutoff select did not take the written value.");

  a_antialias_write: assert property (
    wr && hit(index, power_mode_pkg::BIAS_CURRENT_IDX) |=>
      O_ANTIALIAS_CURRENT_SEL == $past(I_WB_DAT[power_mode_pkg::ANTIALIAS_CURRENT_BIT]))
    else $error("Antialias current did not take the written value.");

  // A store without the low byte lane must not power a block by accident.
  a_sel_refused: assert property (
    I_WB_CYC && I_WB_STB && I_WB_WE && !I_WB_SEL[0] && !O_WB_ACK |=>
      $stable(O_REFERENCE_POWER_EN))
    else $error("Write without byte select changed an enable.");

  a_reset_modes: assert property (@(posedge I_CLK_SYS) disable iff (1'b0)
    !I_RST_N |=> !O_RF_AMP_LOW_POWER_SEL && !O_DIVIDER_HIGH_POWER_SEL &&
                 O_ATTENUATION_STEP == 2'h0 && !O_ATTENUATOR_POWER_EN && !O_ADC_POWER_EN)
    else $error("Reset did not clear the mode selects.");

  c_both_rf_enabled: cover property (
    power_en_c[power_mode_pkg::LOW_NOISE_AMP_BIT] && O_ATTENUATOR_POWER_EN);
  c_divider_by_tx: cover property (O_DIVIDER_POWER_EN && !O_RECEIVE_PATH_POWER_EN);
  c_heavy_atten: cover property (O_ATTENUATION_STEP == 2'h3);
  c_refused_store: cover property (I_WB_CYC && I_WB_STB && I_WB_WE && !I_WB_SEL[0]);
  c_read_effective: cover property (
    req && !I_WB_WE && hit(index, power_mode_pkg::EFFECTIVE_EN_IDX));

endmodule : rx_tx_power_mode_control
`default_nettype wire

// ===== verification/test_rx_tx_power_mode_control.sv
// Self-checking bench for the power enable and mode control block.
`timescale 1ns/1ns
`default_nettype none
module test_rx_tx_power_mode_control;
  logic clk, rst_n, cyc, stb, we, pin, ack;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat;
  logic ref_en, mod_en, syn_en, rate_en, clkb_en, tx_en, det_en, pdet_en, att_en, lna_en;
  logic adc_en, rx_en, div_en, reg_en, amp_lp, div_hp, cut, aaf;
  logic [1:0] gain, step;
  logic [7:0] sh [0:255];
  logic [7:0] idx_l [8] = '{8'h1a, 8'h1b, 8'h33, 8'h6d, 8'h6e, 8'h6f, 8'h70, 8'h75};
  logic [7:0] mode_l [4] = '{8'h1a, 8'h1b, 8'h33, 8'h75};
  logic [31:0] exp_q [$];
  int n_mismatch = 0;
  int n_compared = 0;

  rx_tx_power_mode_control i_rx_tx_power_mode_control (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_REGULATOR_OFF_PIN(pin), .O_REGULATOR_POWER_EN(reg_en), .O_REFERENCE_POWER_EN(ref_en),
    .O_MOD_CONVERTER_POWER_EN(mod_en), .O_SYNTH_POWER_EN(syn_en),
    .O_RATE_CONVERTER_POWER_EN(rate_en), .O_CLOCK_BUFFER_POWER_EN(clkb_en),
    .O_TRANSMIT_PATH_POWER_EN(tx_en), .O_DETECTOR_CONVERTER_POWER_EN(det_en),
    .O_POWER_DETECTOR_EN(pdet_en), .O_ATTENUATOR_POWER_EN(att_en),
    .O_LOW_NOISE_AMP_POWER_EN(lna_en), .O_ADC_POWER_EN(adc_en), .O_RECEIVE_PATH_POWER_EN(rx_en),
    .O_DIVIDER_POWER_EN(div_en), .O_RF_AMP_LOW_POWER_SEL(amp_lp),
    .O_DIVIDER_HIGH_POWER_SEL(div_hp), .O_BASEBAND_CUTOFF_SEL(cut),
    .O_GAIN_AMP_CURRENT_SEL(gain), .O_ANTIALIAS_CURRENT_SEL(aaf), .O_ATTENUATION_STEP(step)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [7:0] msk(input logic [7:0] idx);
    case (idx)
      8'h1a, 8'h33: msk = 8'h03;
      8'h1b: msk = 8'h01;
      8'h6d: msk = 8'h0f;
      8'h6e, 8'h75: msk = 8'h07;
      8'h6f: msk = 8'h1f;
      default: msk = 8'h00;
    endcase
  endfunction : msk

  // Effective state readback is derived from the shadow copy, never from the outputs.
  function automatic logic [7:0] eff();
    logic [7:0] b;
    logic [7:0] c;
    b = sh[8'h6e];
    c = sh[8'h6f];
    eff = {4'h0, ~pin, c[4] | b[1], c[1], c[2] & ~c[1]};
  endfunction : eff

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic s0);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    sel <= {3'b000, s0};
    wdat <= {24'h000000, d};
    if (!w) exp_q.push_back({24'h000000, (idx == 8'h70) ? eff() : sh[idx]});
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    if (w && s0) sh[idx] = d & msk(idx);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rdall();
    foreach (idx_l[k]) wb(1'b0, idx_l[k], 8'h00, 1'b1);
  endtask : rdall

  task automatic outs();
    logic [7:0] b;
    logic [7:0] c;
    @(negedge clk);
    b = sh[8'h6e];
    c = sh[8'h6f];
    chk(32'({clkb_en, rate_en, mod_en, ref_en}), 32'(sh[8'h6d]));
    chk(32'({det_en, tx_en, syn_en}), 32'(b));
    chk(32'({rx_en, adc_en, pdet_en}), 32'({c[4], c[3], c[0]}));
    chk(32'({lna_en, att_en}), 32'({c[2] & ~c[1], c[1]}));
    chk(32'(div_en), 32'(c[4] | b[1]));
    chk(32'(reg_en), 32'(!pin));
    chk(32'({cut, amp_lp}), 32'(sh[8'h1a]));
    chk(32'({aaf, gain, div_hp}), 32'({sh[8'h75][2:0], sh[8'h1b][0]}));
    chk(32'(step), 32'(sh[8'h33]));
  endtask : outs

  // Read data is compared only at the edge where the master takes it.
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) chk(32'h1, 32'h0);
      else chk(rdat, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    pin = 1'b0;
    adr = 10'h000;
    sel = 4'h0;
    wdat = 32'h00000000;
    foreach (sh[k]) sh[k] = 8'h00;
    void'($urandom(12070));
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      cyc <= (i > 8);
      stb <= (i > 8);
      we <= 1'b1;
      adr <= 10'h1b4;
      sel <= 4'h1;
      wdat <= 32'h000000ff;
      @(negedge clk);
      chk(32'(ack), 32'h0);
    end
    @(posedge clk);
    rst_n <= 1'b1;
    cyc <= 1'b0;
    stb <= 1'b0;
    outs();
    rdall();
    $display("test reset done");
    wb(1'b1, 8'h6d, 8'h01, 1'b1);
    wb(1'b1, 8'h6e, 8'($urandom), 1'b1);
    wb(1'b1, 8'h6f, 8'($urandom), 1'b1);
    wb(1'b1, 8'h6d, 8'($urandom) | 8'h01, 1'b1);
    outs();
    rdall();
    wb(1'b1, 8'h6f, 8'h00, 1'b1);
    wb(1'b1, 8'h6e, 8'h00, 1'b1);
    wb(1'b1, 8'h6d, 8'h00, 1'b1);
    outs();
    $display("test power order done");
    wb(1'b1, 8'h6d, 8'h01, 1'b1);
    for (int j = 0; j < 16; j++) begin
      wb(1'b1, 8'h6e, {6'h00, j[2], 1'b0} | 8'($urandom & 32'h5), 1'b1);
      pin <= j[0] ^ j[3];
      wb(1'b1, 8'h6f, {3'h0, j[3], 1'($urandom), j[1], j[0], 1'($urandom)}, 1'b1);
      outs();
      wb(1'b0, 8'h70, 8'h00, 1'b1);
    end
    $display("test amplifier decode done");
    for (int i = 0; i < 8; i++) begin
      foreach (mode_l[k]) wb(1'b1, mode_l[k], (8'($urandom) & 8'hfc) | 8'(i & 3), 1'b1);
      outs();
      rdall();
    end
    $display("test mode decode done");
    wb(1'b1, 8'h70, 8'hff, 1'b1);
    wb(1'b1, 8'h6d, 8'h0e, 1'b0);
    wb(1'b1, 8'h40, 8'hff, 1'b1);
    wb(1'b0, 8'h40, 8'h00, 1'b1);
    wb(1'b0, 8'hff, 8'h00, 1'b1);
    rdall();
    outs();
    $display("test refused access done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (sh[k]) sh[k] = 8'h00;
    outs();
    rdall();
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule : test_rx_tx_power_mode_control
`default_nettype wire
